/* hdl/psld_top.sv */
/*
 Digital section of an integer-N synthesizer: three-wire serial shift
 register, four latches, reference and feedback dividers, band select
 timing, lock detect, monitor output and output muting.
 Assumes every pin input is asynchronous to core_clk and slow enough to
 be sampled by it after a two-stage synchroniser.
*/
// Contract
// R1: Shift one bit per serial rising edge, MSB first
// R2: Load strobe rise copies word into selected latch
// R3: Select codes: control, reference, feedback, test
// R4: Feedback divides by B times P plus A
// R5: Host keeps ratio at least P squared minus P
// R6: Main counter 3..8191, swallow counter 0..31
// R7: Host keeps prescaler output at most 300 MHz
// R8: Fourteen-bit reference divider, ratio 1 to 16383
// R9: Two reference latch bits set antibacklash width
// R10: Three control bits choose monitor pin source
// R11: Normal lock needs three good cycles
// R12: Precise lock needs five, drops above 25 ns
// R13: Band select five cycles at power-up, feedback write
// R14: Host writes reference, control, then feedback latch
// R15: Band clock divides reference output by 1,2,4,8
// R16: Feedback latch bit 22 enables output halving
// R17: Two control bits select core current
// R18: Two control bits select output tail current
// R19: Mute-until-lock keeps RF supply off until lock
// R20: Host never writes the test latch
// R21: Chip enable low powers down, pump three-state
// R22: Latches hold while load strobe stays low
`timescale 1ns/1ps
module psld_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_load_strobe,
   input wire logic reference_input,
   input wire logic feedback_input,
   input wire logic chip_enable,
   output logic monitor_output_pin,
   output logic monitor_output_oe,
   output logic charge_pump_hiz,
   output logic device_active,
   output logic rf_supply_on,
   output logic vtune_internal_ref,
   output logic lock_detect,
   output logic [1:0] antibacklash_width,
   output logic halve_output_sel,
   output logic [1:0] core_current_sel,
   output logic [1:0] output_level_sel
);
   localparam int PIN_SCLK = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_LE = 2;
   localparam int PIN_REF = 3;
   localparam int PIN_FB = 4;
   localparam int PIN_CE = 5;

   function automatic logic psld_rise(input logic cur, input logic prev);
      psld_rise = cur & ~prev;
   endfunction : psld_rise

   // Two-stage synchronisers; the edge detectors compare the second stage with its delayed copy pin_prev
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic [5:0] pin_prev;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
         pin_prev <= 6'h00;
      end
      else
      begin
         pin_meta <= {chip_enable, feedback_input, reference_input,
                      latch_load_strobe, serial_data, serial_clk};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   logic sclk_rise;
   logic le_rise;
   logic ref_edge;
   logic vco_edge;
   logic ce_s;
   logic ce_rise;
   assign sclk_rise = psld_rise(pin_sync[PIN_SCLK], pin_prev[PIN_SCLK]);
   assign le_rise = psld_rise(pin_sync[PIN_LE], pin_prev[PIN_LE]);
   assign ref_edge = psld_rise(pin_sync[PIN_REF], pin_prev[PIN_REF]);
   assign vco_edge = psld_rise(pin_sync[PIN_FB], pin_prev[PIN_FB]);
   assign ce_s = pin_sync[PIN_CE];
   assign ce_rise = psld_rise(pin_sync[PIN_CE], pin_prev[PIN_CE]);

   // Serial shift register
   logic [psld_pkg::WORD_W-1:0] shift_reg;
   always_ff @(posedge core_clk)
   begin
      if (rst)
         shift_reg <= psld_pkg::LATCH_RST;
      else if (sclk_rise)
         shift_reg <= {shift_reg[psld_pkg::WORD_W-2:0], pin_sync[PIN_SDATA]}; // [R1]
   end

   // Latches
   logic [psld_pkg::WORD_W-1:0] ctrl_latch_reg;
   logic [psld_pkg::WORD_W-1:0] ref_latch_reg;
   logic [psld_pkg::WORD_W-1:0] fb_latch_reg;
   logic [psld_pkg::WORD_W-1:0] test_latch_reg;
   logic [1:0] word_sel;
   logic fb_write;
   logic ctrl_write;
   assign word_sel = shift_reg[psld_pkg::SEL_LSB+1:0];
   assign fb_write = le_rise && (word_sel == psld_pkg::SEL_FB);
   assign ctrl_write = le_rise && (word_sel == psld_pkg::SEL_CTRL);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl_latch_reg <= psld_pkg::LATCH_RST;
         ref_latch_reg <= psld_pkg::LATCH_RST;
         fb_latch_reg <= psld_pkg::LATCH_RST;
         test_latch_reg <= psld_pkg::LATCH_RST;
      end
      else if (le_rise) // [R22]
      begin
         if (word_sel == psld_pkg::SEL_CTRL) // [R2] [R3]
            ctrl_latch_reg <= shift_reg;
         else if (word_sel == psld_pkg::SEL_REF)
            ref_latch_reg <= shift_reg;
         else if (word_sel == psld_pkg::SEL_FB)
            fb_latch_reg <= shift_reg;
         else
            test_latch_reg <= shift_reg; // Stored only; drives nothing
      end
   end

   // Latch fields
   logic [1:0] presc_sel;
   logic [2:0] mon_sel;
   logic mute_until_lock;
   logic counter_hold;
   logic lock_precision_sel;
   logic [1:0] band_clk_div;
   logic [psld_pkg::R_W-1:0] r_div;
   logic [psld_pkg::B_W-1:0] b_val;
   logic [psld_pkg::A_W-1:0] a_val;
   assign presc_sel = ctrl_latch_reg[psld_pkg::CTRL_PRESC_LSB+:2];
   assign mon_sel = ctrl_latch_reg[psld_pkg::CTRL_MON_LSB+:3]; // [R10]
   assign mute_until_lock = ctrl_latch_reg[psld_pkg::CTRL_MUTE_UNTIL_LOCK_BIT];
   assign counter_hold = ctrl_latch_reg[psld_pkg::CTRL_CR_BIT];
   assign core_current_sel = ctrl_latch_reg[psld_pkg::CTRL_PC_LSB+:2]; // [R17]
   assign output_level_sel = ctrl_latch_reg[psld_pkg::CTRL_PL_LSB+:2]; // [R18]
   assign lock_precision_sel = ref_latch_reg[psld_pkg::REF_LDP_BIT];
   assign band_clk_div = ref_latch_reg[psld_pkg::REF_BSC_LSB+:2];
   assign antibacklash_width = ref_latch_reg[psld_pkg::REF_ABP_LSB+:2]; // [R9]
   assign r_div = ref_latch_reg[psld_pkg::REF_R_LSB+:psld_pkg::R_W];
   assign b_val = fb_latch_reg[psld_pkg::FB_B_LSB+:psld_pkg::B_W];
   assign a_val = fb_latch_reg[psld_pkg::FB_A_LSB+:psld_pkg::A_W];
   assign halve_output_sel = fb_latch_reg[psld_pkg::FB_HALVE_BIT]; // [R16]

   // Power state
   logic powered;
   logic run;
   assign powered = ce_s && !ctrl_latch_reg[psld_pkg::CTRL_PD1_BIT]; // [R21]
   assign run = powered && !counter_hold;
   assign device_active = powered;
   assign charge_pump_hiz = !powered || ctrl_latch_reg[psld_pkg::CTRL_CPTRI_BIT]; // [R21]

   // Reference divider; a zero ratio behaves as one
   logic [psld_pkg::R_W-1:0] ref_cnt_reg;
   logic [psld_pkg::R_W-1:0] ref_top;
   logic r_pulse;
   assign ref_top = (r_div == '0) ? '0 : r_div - 14'h0001;
   always_ff @(posedge core_clk)
   begin
      if (rst || !run)
      begin
         ref_cnt_reg <= '0;
         r_pulse <= 1'b0;
      end
      else
      begin
         r_pulse <= 1'b0;
         if (ref_edge)
         begin
            if (ref_cnt_reg >= ref_top)
            begin
               ref_cnt_reg <= '0; // [R8]
               r_pulse <= 1'b1;
            end
            else
               ref_cnt_reg <= ref_cnt_reg + 14'h0001;
         end
      end
   end

   logic n_pulse;
   psld_fb_div u_fb_div (
      .core_clk(core_clk),
      .rst(rst),
      .run(run),
      .reload(fb_write || ctrl_write),
      .vco_edge(vco_edge),
      .presc_sel(presc_sel),
      .b_val(b_val),
      .a_val(a_val),
      .n_pulse(n_pulse),
      .modulus_high()
   );

   // Band select: clock is the reference output divided by 1, 2, 4 or 8
   logic [2:0] bclk_cnt_reg;
   logic [2:0] bclk_mask;
   logic band_tick;
   logic [2:0] band_left_reg;
   logic band_start;
   logic start_pend_reg;
   assign bclk_mask = 3'((4'h1 << band_clk_div) - 4'h1);
   assign band_tick = r_pulse && ((bclk_cnt_reg & bclk_mask) == 3'h0); // [R15]
   assign band_start = fb_write || ce_rise || start_pend_reg; // [R13]
   always_ff @(posedge core_clk)
   begin
      if (rst)
         bclk_cnt_reg <= 3'h0;
      else if (band_start)
         bclk_cnt_reg <= 3'h0;
      else if (r_pulse)
         bclk_cnt_reg <= bclk_cnt_reg + 3'h1;
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         start_pend_reg <= 1'b1;
         band_left_reg <= 3'h0;
      end
      else
      begin
         start_pend_reg <= 1'b0;
         if (band_start)
            band_left_reg <= psld_pkg::BAND_PFD_CYCLES; // [R13]
         else if (band_tick && band_left_reg != 3'h0)
            band_left_reg <= band_left_reg - 3'h1;
      end
   end
   assign vtune_internal_ref = (band_left_reg != 3'h0); // [R13]

   // Phase error timing between reference and feedback pulses
   psld_pkg::psld_pfd_e pfd_state;
   logic [psld_pkg::ERR_W-1:0] pfd_cnt_reg;
   logic [psld_pkg::ERR_W-1:0] pfd_cnt_inc;
   psld_pkg::psld_pfd_s pfd_reg;
   assign pfd_cnt_inc = (pfd_cnt_reg == '1) ? pfd_cnt_reg : pfd_cnt_reg + 6'h01;
   always_ff @(posedge core_clk)
   begin
      if (rst || !run)
      begin
         pfd_state <= psld_pkg::PFD_IDLE;
         pfd_cnt_reg <= 6'h00;
         pfd_reg <= '0;
      end
      else
      begin
         pfd_reg.valid <= 1'b0;
         case (pfd_state)
            psld_pkg::PFD_IDLE:
            begin
               pfd_cnt_reg <= 6'h00;
               if (r_pulse && n_pulse)
                  pfd_reg <= '{valid: 1'b1, err: 6'h00};
               else if (r_pulse)
                  pfd_state <= psld_pkg::PFD_WAIT_N;
               else if (n_pulse)
                  pfd_state <= psld_pkg::PFD_WAIT_R;
            end
            psld_pkg::PFD_WAIT_N,
            psld_pkg::PFD_WAIT_R:
            begin
               pfd_cnt_reg <= pfd_cnt_inc;
               if ((pfd_state == psld_pkg::PFD_WAIT_N) ? n_pulse : r_pulse)
               begin
                  pfd_reg <= '{valid: 1'b1, err: pfd_cnt_inc};
                  pfd_state <= psld_pkg::PFD_IDLE;
               end
               else if ((pfd_state == psld_pkg::PFD_WAIT_N) ? r_pulse : n_pulse)
                  pfd_reg <= '{valid: 1'b1, err: 6'h3f}; // Missed cycle counts as large
            end
            default:
               pfd_state <= psld_pkg::PFD_IDLE;
         endcase
      end
   end

   psld_lock_det u_lock_det (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!run || vtune_internal_ref),
      .precise(lock_precision_sel),
      .pfd(pfd_reg),
      .lock_detect(lock_detect)
   );

   // Monitor pin and RF output muting
   logic analog_lock;
   assign analog_lock = (pfd_state == psld_pkg::PFD_IDLE);
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         monitor_output_pin <= 1'b0;
         monitor_output_oe <= 1'b0;
      end
      else if (mon_sel == psld_pkg::MON_HIZ) // [R10]
      begin
         monitor_output_pin <= 1'b0;
         monitor_output_oe <= 1'b0;
      end
      else if (mon_sel == psld_pkg::MON_ALOCK)
      begin
         // Open drain: pulls low only while a phase error is being timed
         monitor_output_pin <= 1'b0;
         monitor_output_oe <= !analog_lock;
      end
      else
      begin
         monitor_output_oe <= 1'b1;
         if (mon_sel == psld_pkg::MON_DLOCK)
            monitor_output_pin <= lock_detect;
         else if (mon_sel == psld_pkg::MON_NDIV)
            monitor_output_pin <= n_pulse;
         else if (mon_sel == psld_pkg::MON_RDIV)
            monitor_output_pin <= r_pulse;
         else
            monitor_output_pin <= (mon_sel == psld_pkg::MON_HIGH);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         rf_supply_on <= 1'b0;
      else
         rf_supply_on <= powered && (!mute_until_lock || lock_detect); // [R19]
   end

   sequence word_to_ctrl_s;
      le_rise && word_sel == psld_pkg::SEL_CTRL;
   endsequence
   sequence word_to_fb_s;
      le_rise && word_sel == psld_pkg::SEL_FB;
   endsequence

   shift_capture_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
      sclk_rise |=> shift_reg == {$past(shift_reg[22:0]), $past(pin_sync[PIN_SDATA])})
      else $error("serial bit not shifted in at the low end");
   ctrl_route_a: assert property (@(posedge core_clk) disable iff (rst) // [R2] [R3]
      word_to_ctrl_s |=> ctrl_latch_reg == $past(shift_reg) && $stable(fb_latch_reg))
      else $error("control word not routed to the control latch");
   fb_route_a: assert property (@(posedge core_clk) disable iff (rst) // [R3] [R16]
      word_to_fb_s |=> halve_output_sel == $past(shift_reg[22]) && $stable(ref_latch_reg))
      else $error("feedback word not routed to the feedback latch");
   latch_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [R22]
      !le_rise |=> $stable(ctrl_latch_reg) && $stable(ref_latch_reg) && $stable(fb_latch_reg))
      else $error("latch changed without a load strobe edge");
   ref_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // [R8]
      r_pulse |-> ref_cnt_reg == '0 && $past(ref_edge))
      else $error("reference pulse without a divider wrap");
   band_run_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
      word_to_fb_s ##1 !band_start[*2] |-> vtune_internal_ref[*2])
      else $error("band select not running after feedback write");
   band_tick_a: assert property (@(posedge core_clk) disable iff (rst) // [R15]
      band_tick && band_clk_div == 2'h3 |-> bclk_cnt_reg[2:0] == 3'h0)
      else $error("band clock tick off its divide-by-eight phase");
   mute_a: assert property (@(posedge core_clk) disable iff (rst) // [R19]
      (mute_until_lock && !lock_detect)[*2] |-> !rf_supply_on)
      else $error("RF supply on while muted and unlocked");
   power_down_a: assert property (@(posedge core_clk) disable iff (rst) // [R21]
      !ce_s |-> charge_pump_hiz ##1 !rf_supply_on)
      else $error("chip enable low but pump or output still active");
   monitor_lock_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
      (mon_sel == psld_pkg::MON_DLOCK)[*2] |-> monitor_output_oe &&
         monitor_output_pin == $past(lock_detect))
      else $error("monitor pin does not follow digital lock");
endmodule : psld_top

/* hdl/psld_pkg.sv */
/*
 Package for the synthesizer digital section: latch select codes, field
 positions inside the 24-bit latch words, reset values, monitor and
 prescaler codes, lock and band-select timing, and the shared carriers.
 Assumes a single 125 MHz core clock for every timing figure.
*/
package psld_pkg;
   localparam int WORD_W = 24;
   localparam int B_W = 13;
   localparam int A_W = 5;
   localparam int R_W = 14;
   localparam int ERR_W = 6;

   // Latch select codes in the two low bits of a word
   localparam int SEL_LSB = 0;
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_REF = 2'h1;
   localparam logic [1:0] SEL_FB = 2'h2;
   localparam logic [1:0] SEL_TEST = 2'h3;

   // Control latch fields
   localparam int CTRL_PRESC_LSB = 22;
   localparam int CTRL_PD1_BIT = 20;
   localparam int CTRL_PL_LSB = 12;
   localparam int CTRL_MUTE_UNTIL_LOCK_BIT = 11;
   localparam int CTRL_CPTRI_BIT = 9;
   localparam int CTRL_MON_LSB = 5;
   localparam int CTRL_CR_BIT = 4;
   localparam int CTRL_PC_LSB = 2;
   // Feedback divider latch fields
   localparam int FB_HALVE_BIT = 22;
   localparam int FB_B_LSB = 8;
   localparam int FB_A_LSB = 2;
   // Reference divider latch fields
   localparam int REF_BSC_LSB = 20;
   localparam int REF_LDP_BIT = 18;
   localparam int REF_ABP_LSB = 16;
   localparam int REF_R_LSB = 2;

   localparam logic [WORD_W-1:0] LATCH_RST = 24'h00_0000;
   localparam logic [B_W-1:0] B_MIN = 13'h0003;

   localparam logic [1:0] PRESC_8 = 2'h0;
   localparam logic [1:0] PRESC_16 = 2'h1;

   localparam logic [2:0] MON_HIZ = 3'h0;
   localparam logic [2:0] MON_DLOCK = 3'h1;
   localparam logic [2:0] MON_NDIV = 3'h2;
   localparam logic [2:0] MON_HIGH = 3'h3;
   localparam logic [2:0] MON_RDIV = 3'h4;
   localparam logic [2:0] MON_ALOCK = 3'h5;

   localparam int CLK_NS = 8;
   localparam int LOCK_GOOD_NS = 15;
   localparam int LOCK_BAD_NS = 25;
   // Error below GOOD counts as good; error above BAD counts as lost
   localparam logic [ERR_W-1:0] LOCK_GOOD_CYC = ERR_W'((LOCK_GOOD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [ERR_W-1:0] LOCK_BAD_CYC = ERR_W'(LOCK_BAD_NS / CLK_NS);
   localparam logic [2:0] LOCK_CNT_FAST = 3'h3;
   localparam logic [2:0] LOCK_CNT_SLOW = 3'h5;
   localparam logic [2:0] BAND_PFD_CYCLES = 3'h5;

   typedef struct packed {
      logic valid;
      logic [ERR_W-1:0] err;
   } psld_pfd_s;

   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_WAIT_N = 2'b01,
      PFD_WAIT_R = 2'b10
   } psld_pfd_e;
endpackage : psld_pkg

/* hdl/psld_fb_div.sv */
/*
 Feedback divider: dual-modulus prescaler with swallow (A) and main (B)
 counters, one pulse per B*P+A input edges.
 Assumes vco_edge is a one-cycle pulse, never in two adjacent cycles.
*/
`timescale 1ns/1ps
module psld_fb_div (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic reload,
   input wire logic vco_edge,
   input wire logic [1:0] presc_sel,
   input wire logic [psld_pkg::B_W-1:0] b_val,
   input wire logic [psld_pkg::A_W-1:0] a_val,
   output logic n_pulse,
   output logic modulus_high
);
   logic [5:0] presc_cnt_reg;
   logic [psld_pkg::B_W-1:0] b_left_reg;
   logic [psld_pkg::A_W-1:0] a_left_reg;
   logic [psld_pkg::B_W-1:0] b_eff;
   logic [5:0] p_val;
   logic [5:0] presc_top;

   assign p_val = (presc_sel == psld_pkg::PRESC_8) ? 6'h08 :
                  (presc_sel == psld_pkg::PRESC_16) ? 6'h10 : 6'h20; // [R4]
   // Main counter values below its minimum run as the minimum
   assign b_eff = (b_val < psld_pkg::B_MIN) ? psld_pkg::B_MIN : b_val; // [R6]
   assign modulus_high = (a_left_reg != '0);
   assign presc_top = modulus_high ? p_val : p_val - 6'h01;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         presc_cnt_reg <= 6'h00;
         b_left_reg <= psld_pkg::B_MIN;
         a_left_reg <= '0;
         n_pulse <= 1'b0;
      end
      else if (reload || !run)
      begin
         presc_cnt_reg <= 6'h00;
         b_left_reg <= b_eff;
         a_left_reg <= a_val;
         n_pulse <= 1'b0;
      end
      else
      begin
         n_pulse <= 1'b0;
         if (vco_edge)
         begin
            if (presc_cnt_reg == presc_top)
            begin
               presc_cnt_reg <= 6'h00;
               if (b_left_reg <= 13'h0001)
               begin
                  b_left_reg <= b_eff; // [R4]
                  a_left_reg <= a_val;
                  n_pulse <= 1'b1;
               end
               else
               begin
                  b_left_reg <= b_left_reg - 13'h0001;
                  if (modulus_high)
                     a_left_reg <= a_left_reg - 5'h01;
               end
            end
            else
               presc_cnt_reg <= presc_cnt_reg + 6'h01;
         end
      end
   end

   // Helper: edges seen since the last output pulse
   logic [18:0] edge_cnt;
   logic armed;
   always_ff @(posedge core_clk)
   begin
      if (rst || reload || !run)
      begin
         edge_cnt <= '0;
         armed <= 1'b0;
      end
      else if (n_pulse)
      begin
         edge_cnt <= '0;
         armed <= 1'b1;
      end
      else if (vco_edge)
         edge_cnt <= edge_cnt + 19'h0_0001;
   end

   ratio_exact_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
      n_pulse && armed |-> edge_cnt == 19'(b_eff * p_val) + 19'(a_val))
      else $error("feedback ratio differs from B*P+A");
endmodule : psld_fb_div

/* hdl/psld_lock_det.sv */
/*
 Digital lock detect: counts consecutive phase detector cycles with small
 error and holds the active-high lock flag.
 Assumes one pfd.valid pulse per phase detector cycle.
*/
`timescale 1ns/1ps
module psld_lock_det (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic precise,
   input wire psld_pkg::psld_pfd_s pfd,
   output logic lock_detect
);
   logic [2:0] good_cnt_reg;
   logic [2:0] good_cnt_next;
   logic good;
   logic bad;
   logic [2:0] need;

   assign good = pfd.err < psld_pkg::LOCK_GOOD_CYC;
   assign bad = pfd.err > psld_pkg::LOCK_BAD_CYC;
   assign need = precise ? psld_pkg::LOCK_CNT_SLOW : psld_pkg::LOCK_CNT_FAST;
   assign good_cnt_next = (good_cnt_reg == 3'h7) ? good_cnt_reg : good_cnt_reg + 3'h1;

   always_ff @(posedge core_clk)
   begin
      if (rst || clear)
      begin
         good_cnt_reg <= 3'h0;
         lock_detect <= 1'b0;
      end
      else if (pfd.valid)
      begin
         if (precise && lock_detect)
         begin
            // Precise mode keeps lock through mid-size errors
            if (bad)
            begin
               lock_detect <= 1'b0; // [R12]
               good_cnt_reg <= 3'h0;
            end
         end
         else if (good)
         begin
            good_cnt_reg <= good_cnt_next;
            if (good_cnt_next >= need)
               lock_detect <= 1'b1; // [R11] [R12]
         end
         else
         begin
            good_cnt_reg <= 3'h0;
            lock_detect <= 1'b0; // [R11]
         end
      end
   end

   lock_count_a: assert property (@(posedge core_clk) disable iff (rst) // [R11]
      $rose(lock_detect) |-> $past(good_cnt_reg) + 3'h1 >= $past(need))
      else $error("lock asserted before enough good cycles");
   precise_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
      precise && lock_detect && pfd.valid && !bad && !clear |=> lock_detect)
      else $error("precise lock dropped without a large error");
endmodule : psld_lock_det

/* test/psld_host_model.sv */
/*
 Host model: shifts 24-bit words MSB first, then optionally raises the load strobe.
 Assumes a 125 MHz core_clk; each pin level is held for four core clocks.
*/
`timescale 1ns/1ps
module psld_host_model (
   input wire logic core_clk,
   output logic serial_clk,
   output logic serial_data,
   output logic latch_load_strobe
);
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      latch_load_strobe = 1'b0;
   end
   task automatic hold4();
      repeat (4) @(posedge core_clk);
      #1;
   endtask : hold4
   task automatic send(input logic [23:0] word, input logic load);
      for (int i = 23; i >= 0; i--)
      begin
         serial_data = word[i];
         hold4();
         serial_clk = 1'b1;
         hold4();
         serial_clk = 1'b0;
      end
      // Released data line shows the inverse of the last bit
      serial_data = ~word[0];
      hold4();
      latch_load_strobe = load && (word[1:0] != 2'b11);
      hold4();
      latch_load_strobe = 1'b0;
      hold4();
   endtask : send
endmodule : psld_host_model

/* test/psld_top_test.sv */
/*
 Testbench: programs the latches through the host model and checks outputs.
 Assumes core_clk at 125 MHz and a slow free-running reference input.
*/
`timescale 1ns/1ps
module psld_top_test;
   logic core_clk, rst, reference_input, feedback_input, chip_enable, serial_clk;
   logic serial_data, latch_load_strobe, monitor_output_pin, monitor_output_oe;
   logic charge_pump_hiz, device_active, rf_supply_on, vtune_internal_ref, lock_detect;
   logic halve_output_sel;
   logic [1:0] antibacklash_width, core_current_sel, output_level_sel;
   int failures = 0;
   int cmp_count = 0;
   psld_host_model psld_host_model_i (.core_clk(core_clk), .serial_clk(serial_clk),
      .serial_data(serial_data), .latch_load_strobe(latch_load_strobe));
   psld_top psld_top_i (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
      .serial_data(serial_data), .latch_load_strobe(latch_load_strobe),
      .reference_input(reference_input), .feedback_input(feedback_input),
      .chip_enable(chip_enable), .monitor_output_pin(monitor_output_pin),
      .monitor_output_oe(monitor_output_oe), .charge_pump_hiz(charge_pump_hiz),
      .device_active(device_active), .rf_supply_on(rf_supply_on),
      .vtune_internal_ref(vtune_internal_ref), .lock_detect(lock_detect),
      .antibacklash_width(antibacklash_width), .halve_output_sel(halve_output_sel),
      .core_current_sel(core_current_sel), .output_level_sel(output_level_sel));
   // Feedback pin mirrors the reference so both dividers count the same edges
   assign feedback_input = reference_input;
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic test_power_up();
      psld_host_model_i.send(24'h02_0011, 1'b1);
      chk(antibacklash_width, 2'h2);
      psld_host_model_i.send(24'h40_3068, 1'b1);
      chk(output_level_sel, 2'h3);
      chk(core_current_sel, 2'h2);
      chk({1'b0, monitor_output_pin}, 2'h1);
      chk({1'b0, rf_supply_on}, 2'h1);
      psld_host_model_i.send(24'h40_0f02, 1'b1);
      chk({1'b0, halve_output_sel}, 2'h1);
      chk({1'b0, vtune_internal_ref}, 2'h1);
      for (int i = 0; i < 400 && vtune_internal_ref === 1'b1; i++)
         tick(1);
      chk({1'b0, vtune_internal_ref}, 2'h0);
   endtask : test_power_up
   task automatic test_hold_mute();
      psld_host_model_i.send(24'h00_0000, 1'b0);
      chk(antibacklash_width, 2'h2);
      chk(output_level_sel, 2'h3);
      psld_host_model_i.send(24'h00_0800, 1'b1);
      chk(output_level_sel, 2'h0);
      chk({1'b0, rf_supply_on}, 2'h0);
   endtask : test_hold_mute
   task automatic test_chip_enable();
      chip_enable = 1'b0;
      tick(4);
      chk({1'b0, charge_pump_hiz}, 2'h1);
      chk({1'b0, device_active}, 2'h0);
      chip_enable = 1'b1;
      tick(4);
      chk({1'b0, device_active}, 2'h1);
   endtask : test_chip_enable
   task automatic test_lock();
      psld_host_model_i.send(24'h06_00e1, 1'b1);
      psld_host_model_i.send(24'h00_0830, 1'b1);
      psld_host_model_i.send(24'h00_0702, 1'b1);
      psld_host_model_i.send(24'h00_0820, 1'b1);
      for (int i = 0; i < 3000 && vtune_internal_ref === 1'b1; i++)
         tick(1);
      chk({1'b0, vtune_internal_ref}, 2'h0);
      chk({1'b0, lock_detect}, 2'h0);
      tick(1000);
      chk({1'b0, lock_detect}, 2'h0);
      for (int i = 0; i < 1000 && lock_detect !== 1'b1; i++)
         tick(1);
      tick(500);
      chk({1'b0, lock_detect}, 2'h1);
      chk({1'b0, monitor_output_pin}, 2'h1);
      chk({1'b0, monitor_output_oe}, 2'h1);
      chk({1'b0, rf_supply_on}, 2'h1);
   endtask : test_lock
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always
   begin
      tick(4);
      reference_input = ~reference_input;
   end
   initial
   begin
      #200000;
      failures++;
      print_verdict();
   end
   initial
   begin
      rst = 1'b1;
      reference_input = 1'b0;
      chip_enable = 1'b1;
      tick(5);
      rst = 1'b0;
      tick(2);
      test_power_up();
      test_hold_mute();
      test_chip_enable();
      test_lock();
      print_verdict();
   end
endmodule : psld_top_test
